// [hw/can_bit_timer.sv]
// Time-quantum prescaler and bit segment sequencer with jump-limited edge resync.
// Assumes rxLine is synchronous to clock; dominant is 0.
`timescale 1ns/1ps
module can_bit_timer
  import can_irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] prescaler,
  input wire logic [1:0] jumpWidth,
  input wire logic [2:0] propSeg,
  input wire logic rxLine,
  output logic tqTick,
  output logic samplePulse,
  output logic sampledBit
);

  logic [5:0] preCnt_r;
  logic [3:0] segCnt_r;
  logic [3:0] segLen_r;
  segment_e seg_r;
  logic lastRx_r;
  logic [3:0] jumpTq;
  logic edgeSeen;

  assign tqTick = (preCnt_r == prescaler); // see [R17]
  assign jumpTq = {2'b00, jumpWidth} + 4'h1; // see [R19]
  assign edgeSeen = tqTick && lastRx_r && !rxLine; // see [R18]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_r <= 6'h00;
    end else if (tqTick) begin
      preCnt_r <= 6'h00;
    end else begin
      preCnt_r <= preCnt_r + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lastRx_r <= 1'b1;
    end else if (tqTick) begin
      lastRx_r <= rxLine;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seg_r <= SEG_SYNC;
      segCnt_r <= 4'h0;
      segLen_r <= 4'h1;
    end else if (tqTick) begin
      unique case (seg_r)
        SEG_SYNC: begin
          seg_r <= SEG_PROP;
          segCnt_r <= 4'h0;
          segLen_r <= {1'b0, propSeg} + 4'h1; // see [R20]
        end
        SEG_PROP, SEG_PHASE1: begin
          if (edgeSeen) begin
            segLen_r <= segLen_r + jumpTq; // see [R19]
          end
          if (segCnt_r + 4'h1 >= segLen_r && !edgeSeen) begin
            seg_r <= (seg_r == SEG_PROP) ? SEG_PHASE1 : SEG_PHASE2;
            segCnt_r <= 4'h0;
            segLen_r <= (seg_r == SEG_PROP) ? PHASE1_TQ : PHASE2_TQ;
          end else begin
            segCnt_r <= segCnt_r + 4'h1;
          end
        end
        SEG_PHASE2: begin
          // Early edge: cut phase 2 by at most the jump width
          if (edgeSeen && (segLen_r - segCnt_r) <= jumpTq) begin // see [R19]
            seg_r <= SEG_PROP;
            segCnt_r <= 4'h0;
            segLen_r <= {1'b0, propSeg} + 4'h1;
          end else if (edgeSeen) begin
            segLen_r <= segLen_r - jumpTq;
            segCnt_r <= segCnt_r + 4'h1;
          end else if (segCnt_r + 4'h1 >= segLen_r) begin
            seg_r <= SEG_SYNC;
            segCnt_r <= 4'h0;
          end else begin
            segCnt_r <= segCnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // Sample point is the end of phase 1
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      samplePulse <= 1'b0;
      sampledBit <= 1'b1;
    end else begin
      samplePulse <= tqTick && seg_r == SEG_PHASE1 && segCnt_r + 4'h1 >= segLen_r
        && !edgeSeen;
      if (tqTick && seg_r == SEG_PHASE1 && segCnt_r + 4'h1 >= segLen_r && !edgeSeen) begin
        sampledBit <= rxLine;
      end
    end
  end

endmodule

// [hw/can_irq_and_bit_timing_cfg.sv]
// Interrupt flags, enables, per-object status and bit-timing registers.
// Assumes one AHB-Lite master, a frame engine driving event strobes,
// and message-object flag levels kept by the object registers outside.
`timescale 1ns/1ps
module can_irq_and_bit_timing_cfg
  import can_irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire objEvents_s objEvents,
  input wire frameEvents_s frameEvents,
  input wire logic rxLine,
  output logic canIrq,
  output logic tqTick,
  output logic samplePulse,
  output logic sampledBit,
  output logic [5:0] objectInUse
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [6:0] flags_r;
  logic [7:0] genEnable_r;
  logic [5:0] objEnable_r;
  logic [5:0] objIrqEnable_r;
  logic [5:0] objStatus_r;
  logic [5:0] prescale_r;
  logic [1:0] jump_r;
  logic [2:0] prop_r;

  logic dataWrite_r;
  logic [7:0] dataAddr_r;
  logic addrPhase;
  logic [6:0] flagSet;
  logic [6:0] flagClear;
  logic [5:0] objStatusNxt;
  logic summary;
  logic [2:0] sameCount_r;
  logic lastBit_r;
  logic stuffHit;
  logic ackMiss;

  function automatic logic isWrite(input logic [7:0] ofs);
    isWrite = dataWrite_r && dataAddr_r == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait, always OKAY

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataWrite_r <= 1'b0;
      dataAddr_r <= 8'h00;
    end else if (hready) begin
      dataWrite_r <= addrPhase && hwrite;
      dataAddr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= 32'h00000000;
      unique case (haddr[7:0])
        OFS_GENERAL_FLAGS: hrdata[7:0] <= {summary, flags_r};
        OFS_GENERAL_IRQ_ENABLE: hrdata[7:0] <= genEnable_r;
        OFS_OBJECT_ENABLE_LOW: hrdata[5:0] <= objEnable_r; // see [R13]
        OFS_OBJECT_IRQ_ENABLE_LOW: hrdata[5:0] <= objIrqEnable_r;
        OFS_OBJECT_IRQ_STATUS_LOW: hrdata[5:0] <= objStatus_r; // see [R15]
        OFS_BIT_TIMING_PRESCALE: hrdata[7:0] <= {1'b0, prescale_r, 1'b0};
        OFS_BIT_TIMING_JUMP_PROP: hrdata[7:0] <= {1'b0, jump_r, 1'b0, prop_r, 1'b0};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error detection at the sample point

  // Counts identical bits; a sixth identical one is a stuff violation
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sameCount_r <= 3'h0;
      lastBit_r <= 1'b1;
    end else if (!frameEvents.stuffCheck) begin
      sameCount_r <= 3'h0;
    end else if (samplePulse) begin
      lastBit_r <= sampledBit;
      if (sameCount_r != 3'h0 && sampledBit == lastBit_r && sameCount_r < STUFF_LIMIT) begin
        sameCount_r <= sameCount_r + 3'h1;
      end else if (sampledBit != lastBit_r || sameCount_r == 3'h0) begin
        sameCount_r <= 3'h1;
      end
    end
  end

  // samplePulse and sampledBit update together, so sampledBit is the new bit
  assign stuffHit = frameEvents.stuffCheck && samplePulse && sameCount_r == STUFF_LIMIT
    && sampledBit == lastBit_r; // see [R1]
  assign ackMiss = frameEvents.ackSlot && frameEvents.transmitting && samplePulse
    && sampledBit; // see [R4]

  ////////////////////////////////////////////////////////////////////////////
  // General flags: hardware set wins over software clear

  always_comb begin
    flagSet = 7'h00;
    flagSet[POS_BUS_OFF] = frameEvents.busOffEntry;
    flagSet[POS_TIMER_OVERRUN] = frameEvents.timerOverrun;
    flagSet[POS_BUFFER_DONE] = frameEvents.bufferRxDone; // see [R6]
    flagSet[POS_STUFF_ERR] = stuffHit; // see [R1]
    flagSet[POS_CRC_ERR] = frameEvents.crcMismatch; // see [R2]
    flagSet[POS_FORM_ERR] = frameEvents.formViolation; // see [R3]
    flagSet[POS_ACK_ERR] = ackMiss; // see [R4]
    flagClear = isWrite(OFS_GENERAL_FLAGS) ? hwdata[6:0] : 7'h00; // see [R5]
    flagClear[POS_TIMER_OVERRUN] = flagClear[POS_TIMER_OVERRUN]
      || frameEvents.overrunHandled;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= 7'h00;
    end else begin
      flags_r <= flagSet | (flags_r & ~flagClear); // see [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable and timing registers

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      genEnable_r <= RESET_BYTE;
    end else if (isWrite(OFS_GENERAL_IRQ_ENABLE)) begin
      genEnable_r <= hwdata[7:0]; // see [R8]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      objIrqEnable_r <= RESET_OBJECTS;
    end else if (isWrite(OFS_OBJECT_IRQ_ENABLE_LOW)) begin
      objIrqEnable_r <= hwdata[5:0]; // see [R14]
    end
  end

  // Reserved bits are dropped, so a careless write cannot disturb timing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale_r <= 6'h00;
      jump_r <= 2'h0;
      prop_r <= 3'h0;
    end else begin
      if (isWrite(OFS_BIT_TIMING_PRESCALE)) begin
        prescale_r <= hwdata[POS_PRESCALE_LSB +: 6]; // see [R17]
      end
      if (isWrite(OFS_BIT_TIMING_JUMP_PROP)) begin
        jump_r <= hwdata[POS_JUMP_LSB +: 2]; // see [R19]
        prop_r <= hwdata[POS_PROP_LSB +: 3]; // see [R20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message objects

  genvar g;
  generate
    for (g = 0; g < NUM_OBJECTS; g++) begin : gObj
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          objEnable_r[g] <= 1'b0;
        end else if (objEvents.transmit_ok_flag[g] || objEvents.receive_ok_flag[g]) begin
          objEnable_r[g] <= 1'b0; // see [R11]
        end else if (objEvents.cfgDisable[g] || frameEvents.abortReq
            || frameEvents.standbyEntry) begin
          objEnable_r[g] <= 1'b0; // see [R12]
        end else if (objEvents.cfgEnable[g]) begin
          objEnable_r[g] <= 1'b1; // see [R10]
        end
      end

      // Follows the object's flag levels, so it drops once they are cleared
      assign objStatusNxt[g] =
        (objEvents.rxPending[g] && genEnable_r[POS_EN_RECEIVE])
        || (objEvents.txPending[g] && genEnable_r[POS_EN_TRANSMIT])
        || (objEvents.errPending[g] && genEnable_r[POS_EN_OBJ_ERR]); // see [R22] [R25]
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      objStatus_r <= RESET_OBJECTS;
    end else begin
      objStatus_r <= objStatusNxt; // see [R22] [R25]
    end
  end

  assign objectInUse = objEnable_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request

  assign summary = (|flags_r[POS_BUS_OFF:POS_BUS_OFF]) || (|flags_r[POS_BUFFER_DONE:0])
    || (|objStatus_r); // see [R21]

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      canIrq <= 1'b0;
    end else begin
      canIrq <= (genEnable_r[POS_EN_GLOBAL] && ( // see [R7]
          (flags_r[POS_BUS_OFF] && genEnable_r[POS_EN_BUS_OFF])
          || (flags_r[POS_BUFFER_DONE] && genEnable_r[POS_EN_BUFFER])
          || (|flags_r[POS_STUFF_ERR:0] && genEnable_r[POS_EN_GEN_ERR])
          || (|(objStatus_r & objIrqEnable_r))))
        || (flags_r[POS_TIMER_OVERRUN] && genEnable_r[POS_EN_OVERRUN]); // see [R9] [R24]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing

  can_bit_timer uBitTimer (
    .clock(clock),
    .rst_n(rst_n),
    .prescaler(prescale_r),
    .jumpWidth(jump_r),
    .propSeg(prop_r),
    .rxLine(rxLine),
    .tqTick(tqTick),
    .samplePulse(samplePulse),
    .sampledBit(sampledBit)
  );

endmodule

// [hw/can_irq_pkg.sv]
// Constants, field layout and carriers for the CAN interrupt and bit-timing block.
// Assumes an AHB-Lite word bus and a frame engine that reports events as strobes.
// Behaviour
// [R1] Sixth identical sampled bit sets stuff flag
// [R2] CRC mismatch strobe sets CRC flag
// [R3] Delimiter or EOF violation sets form flag
// [R4] Recessive acknowledge slot sets ack flag
// [R5] Flags clear only by writing one; the overrun flag also clears on overrunHandled
// [R6] Buffer reception done sets buffer flag
// [R7] Global enable gates all but overrun
// [R8] Bits six to one enable sources
// [R9] Bit zero enables overrun independently
// [R10] Object configuration sets object in-use bit
// [R11] Transmit or receive OK clears in-use
// [R12] Disable, abort, standby clear in-use
// [R13] Six in-use bits, upper bits read zero
// [R14] Per-object interrupt enable, six bits
// [R15] Per-object pending status, six bits, read-only
// [R16] Software writes zero to reserved bits
// [R17] Quantum is prescaler plus one clocks
// [R18] Resynchronize on each recessive-to-dominant edge
// [R19] Jump limited to quantum times width+1
// [R20] Propagation segment lasts field plus one
// [R21] Summary flag ORs all but overrun
// [R22] Enabled object event sets status bit
// [R23] Software avoids triple sampling at prescaler zero
// [R24] Request asserted for any enabled flag
// [R25] Status clears when object flags cleared

package can_irq_pkg;

  localparam int NUM_OBJECTS = 6;

  localparam logic [7:0] OFS_GENERAL_FLAGS = 8'h00;
  localparam logic [7:0] OFS_GENERAL_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] OFS_OBJECT_ENABLE_LOW = 8'h08;
  localparam logic [7:0] OFS_OBJECT_ENABLE_HIGH = 8'h0c;
  localparam logic [7:0] OFS_OBJECT_IRQ_ENABLE_LOW = 8'h10;
  localparam logic [7:0] OFS_OBJECT_IRQ_ENABLE_HIGH = 8'h14;
  localparam logic [7:0] OFS_OBJECT_IRQ_STATUS_LOW = 8'h18;
  localparam logic [7:0] OFS_OBJECT_IRQ_STATUS_HIGH = 8'h1c;
  localparam logic [7:0] OFS_BIT_TIMING_PRESCALE = 8'h20;
  localparam logic [7:0] OFS_BIT_TIMING_JUMP_PROP = 8'h24;

  // General flag register layout
  localparam int POS_IRQ_SUMMARY = 7;
  localparam int POS_BUS_OFF = 6;
  localparam int POS_TIMER_OVERRUN = 5;
  localparam int POS_BUFFER_DONE = 4;
  localparam int POS_STUFF_ERR = 3;
  localparam int POS_CRC_ERR = 2;
  localparam int POS_FORM_ERR = 1;
  localparam int POS_ACK_ERR = 0;

  // General enable register layout
  localparam int POS_EN_GLOBAL = 7;
  localparam int POS_EN_BUS_OFF = 6;
  localparam int POS_EN_RECEIVE = 5;
  localparam int POS_EN_TRANSMIT = 4;
  localparam int POS_EN_OBJ_ERR = 3;
  localparam int POS_EN_BUFFER = 2;
  localparam int POS_EN_GEN_ERR = 1;
  localparam int POS_EN_OVERRUN = 0;

  // Bit timing fields
  localparam int POS_PRESCALE_LSB = 1;
  localparam int POS_JUMP_LSB = 5;
  localparam int POS_PROP_LSB = 1;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [5:0] RESET_OBJECTS = 6'h00;

  // Phase segments are configured elsewhere; fixed lengths here
  localparam logic [3:0] PHASE1_TQ = 4'h3;
  localparam logic [3:0] PHASE2_TQ = 4'h3;
  localparam logic [2:0] STUFF_LIMIT = 3'h5;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PHASE1, SEG_PHASE2} segment_e;

  typedef struct packed {
    logic [NUM_OBJECTS-1:0] cfgEnable;
    logic [NUM_OBJECTS-1:0] cfgDisable;
    logic [NUM_OBJECTS-1:0] transmit_ok_flag;
    logic [NUM_OBJECTS-1:0] receive_ok_flag;
    logic [NUM_OBJECTS-1:0] rxPending;
    logic [NUM_OBJECTS-1:0] txPending;
    logic [NUM_OBJECTS-1:0] errPending;
  } objEvents_s;

  typedef struct packed {
    logic stuffCheck;
    logic crcMismatch;
    logic formViolation;
    logic ackSlot;
    logic transmitting;
    logic bufferRxDone;
    logic busOffEntry;
    logic timerOverrun;
    logic overrunHandled;
    logic abortReq;
    logic standbyEntry;
  } frameEvents_s;

endpackage

// [test/can_irq_and_bit_timing_cfg_tb.sv]
// Self-checking bench for the CAN interrupt and bit-timing block.
// Assumes a 200 MHz clock, one AHB-Lite master and the far-side node model.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin numErrors++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module can_irq_and_bit_timing_cfg_tb;
  import can_irq_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, canIrq, tqTick, samplePulse, sampledBit, rxLine;
  logic [31:0] hrdata;
  logic [5:0] objectInUse;
  objEvents_s oe = '0;
  frameEvents_s fe = '0;
  logic go = 1'b0;
  int runBits = 0;
  int numErrors = 0;
  int testsRun = 0;
  int cycles = 0;
  assign hready = hreadyout;
  always #2.5 clock = ~clock;
  can_irq_and_bit_timing_cfg i_can_irq_and_bit_timing_cfg (.clock, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .objEvents(oe),
    .frameEvents(fe), .rxLine, .canIrq, .tqTick, .samplePulse, .sampledBit, .objectInUse);
  can_node_model i_can_node_model (.clock, .rst_n, .go, .runBits, .bitClocks(8), .rxLine);
  ////////////////////////////////////////
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    // Only the bench timeout ends a wait
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    `CHK(nm, {24'h0, e}, q)
  endtask
  task automatic irqIs(input logic e);
    // Status, then request, each lag one edge
    repeat (3) @(posedge clock);
    `CHK("canIrq", e, canIrq)
  endtask
  task automatic pulseObj(input objEvents_s v);
    oe <= v;
    @(posedge clock);
    oe <= '0;
    @(posedge clock);
  endtask
  ////////////////////////////////////////
  task automatic testRegs;
    int n;
    for (int a = 0; a <= 'h30; a += 4) chk(8'(a), 8'h00, "reset value");
    wr(OFS_GENERAL_IRQ_ENABLE, 8'hff);
    chk(OFS_GENERAL_IRQ_ENABLE, 8'hff, "gen enable");
    wr(OFS_OBJECT_IRQ_ENABLE_LOW, 8'h3f);
    chk(OFS_OBJECT_IRQ_ENABLE_LOW, 8'h3f, "obj enable");
    wr(OFS_OBJECT_ENABLE_LOW, 8'h3f);
    chk(OFS_OBJECT_ENABLE_LOW, 8'h00, "in-use ro");
    wr(OFS_BIT_TIMING_JUMP_PROP, 8'h6e);
    chk(OFS_BIT_TIMING_JUMP_PROP, 8'h6e, "jump prop");
    wr(OFS_BIT_TIMING_PRESCALE, 8'h06);
    chk(OFS_BIT_TIMING_PRESCALE, 8'h06, "prescale");
    // Tick is read before the edge updates it; spacing is what counts
    n = 0;
    do begin @(posedge clock); n++; end while (!tqTick && n < 20);
    n = 0;
    do begin @(posedge clock); n++; end while (!tqTick && n < 20);
    `CHK("quantum", 4, n)
    // Short bits keep the stuffing runs brief; wide jump aligns on each edge
    wr(OFS_BIT_TIMING_PRESCALE, 8'h00);
    wr(OFS_BIT_TIMING_JUMP_PROP, 8'h60);
    wr(OFS_GENERAL_IRQ_ENABLE, 8'h00);
    wr(OFS_OBJECT_IRQ_ENABLE_LOW, 8'h00);
    $display("done registers");
  endtask
  task automatic testFlags;
    frameEvents_s v;
    v = '0;
    v.crcMismatch = 1'b1;
    v.formViolation = 1'b1;
    v.bufferRxDone = 1'b1;
    v.busOffEntry = 1'b1;
    v.timerOverrun = 1'b1;
    fe <= v;
    @(posedge clock);
    fe <= '0;
    @(posedge clock);
    chk(OFS_GENERAL_FLAGS, 8'hf6, "flags set");
    wr(OFS_GENERAL_FLAGS, 8'h00);
    chk(OFS_GENERAL_FLAGS, 8'hf6, "write zero");
    wr(OFS_GENERAL_FLAGS, 8'h56);
    chk(OFS_GENERAL_FLAGS, 8'h20, "overrun only");
    wr(OFS_GENERAL_IRQ_ENABLE, 8'h01);
    irqIs(1'b1);
    wr(OFS_GENERAL_FLAGS, 8'h20);
    irqIs(1'b0);
    fe.crcMismatch <= 1'b1;
    wr(OFS_GENERAL_IRQ_ENABLE, 8'h02);
    fe.crcMismatch <= 1'b0;
    irqIs(1'b0);
    wr(OFS_GENERAL_IRQ_ENABLE, 8'h82);
    irqIs(1'b1);
    wr(OFS_GENERAL_FLAGS, 8'h04);
    irqIs(1'b0);
    $display("done flags");
  endtask
  task automatic stuffRun(input int bits, input logic [7:0] e);
    fe.stuffCheck <= 1'b1;
    go <= 1'b1;
    runBits <= bits;
    @(posedge clock);
    go <= 1'b0;
    repeat (bits * 8 + 2) @(posedge clock);
    fe.stuffCheck <= 1'b0;
    chk(OFS_GENERAL_FLAGS, e, "stuff run");
  endtask
  task automatic testWire;
    stuffRun(5, 8'h00);
    stuffRun(7, 8'h88);
    wr(OFS_GENERAL_FLAGS, 8'h08);
    fe.ackSlot <= 1'b1;
    fe.transmitting <= 1'b1;
    repeat (16) @(posedge clock);
    fe.ackSlot <= 1'b0;
    fe.transmitting <= 1'b0;
    chk(OFS_GENERAL_FLAGS, 8'h81, "ack error");
    wr(OFS_GENERAL_FLAGS, 8'h01);
    $display("done wire");
  endtask
  task automatic testObjects;
    objEvents_s v;
    v = '0;
    v.cfgEnable = 6'h3f;
    pulseObj(v);
    chk(OFS_OBJECT_ENABLE_LOW, 8'h3f, "in-use set");
    v = '0;
    v.transmit_ok_flag = 6'h01;
    v.receive_ok_flag = 6'h02;
    v.cfgDisable = 6'h04;
    v.cfgEnable = 6'h02;
    pulseObj(v);
    chk(OFS_OBJECT_ENABLE_LOW, 8'h38, "in-use clear");
    fe.abortReq <= 1'b1;
    @(posedge clock);
    fe.abortReq <= 1'b0;
    chk(OFS_OBJECT_ENABLE_LOW, 8'h00, "abort");
    v = '0;
    v.cfgEnable = 6'h30;
    pulseObj(v);
    fe.standbyEntry <= 1'b1;
    @(posedge clock);
    fe.standbyEntry <= 1'b0;
    chk(OFS_OBJECT_ENABLE_LOW, 8'h00, "standby");
    wr(OFS_GENERAL_IRQ_ENABLE, 8'ha0);
    oe.rxPending <= 6'h04;
    oe.txPending <= 6'h08;
    // Status register needs one edge before the read's address phase
    @(posedge clock);
    chk(OFS_OBJECT_IRQ_STATUS_LOW, 8'h04, "status");
    chk(OFS_GENERAL_FLAGS, 8'h80, "summary");
    irqIs(1'b0);
    wr(OFS_OBJECT_IRQ_ENABLE_LOW, 8'h04);
    irqIs(1'b1);
    oe.rxPending <= 6'h00;
    oe.txPending <= 6'h00;
    irqIs(1'b0);
    chk(OFS_OBJECT_IRQ_STATUS_LOW, 8'h00, "status clear");
    $display("done objects");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    testRegs();
    testFlags();
    testWire();
    testObjects();
    summarize();
  end
endmodule
bind can_irq_and_bit_timing_cfg can_irq_monitor i_can_irq_monitor (.clock, .rst_n, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .objEvents, .frameEvents, .objectInUse);

// [test/can_irq_monitor.sv]
// Port checker for the CAN interrupt and bit-timing block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module can_irq_monitor
  import can_irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire objEvents_s objEvents,
  input wire frameEvents_s frameEvents,
  input wire logic [5:0] objectInUse
);
  logic rdTaken;
  logic clrAny;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  assign rdTaken = hsel && htrans[1] && hready && !hwrite;
  assign clrAny = |{objEvents.transmit_ok_flag, objEvents.receive_ok_flag, objEvents.cfgDisable,
                    frameEvents.abortReq, frameEvents.standbyEntry};
  ////////////////////////////////////////
  a_transmit_ok_flag_clears_use:
    assert property ((objEvents.transmit_ok_flag != 6'h00) |=> (objectInUse & $past(objEvents.transmit_ok_flag)) == 6'h00)
    else $error("in-use bit survived transmit ok");
  a_receive_ok_flag_clears_use:
    assert property ((objEvents.receive_ok_flag != 6'h00) |=> (objectInUse & $past(objEvents.receive_ok_flag)) == 6'h00)
    else $error("in-use bit survived receive ok");
  a_disable_clears_use:
    assert property ((objEvents.cfgDisable != 6'h00) |=>
      (objectInUse & $past(objEvents.cfgDisable)) == 6'h00)
    else $error("in-use bit survived disable");
  a_abort_clears_all:
    assert property (frameEvents.abortReq |=> objectInUse == 6'h00)
    else $error("in-use bits survived abort");
  a_standby_clears_all:
    assert property ($rose(frameEvents.standbyEntry) |=> objectInUse == 6'h00)
    else $error("in-use bits survived standby");
  a_enable_sets_use:
    assert property ((objEvents.cfgEnable != 6'h00 && !clrAny) |=>
      (objectInUse & $past(objEvents.cfgEnable)) == $past(objEvents.cfgEnable))
    else $error("in-use bit not set by enable");
  a_inuse_read_back:
    assert property ((rdTaken && haddr[7:0] == OFS_OBJECT_ENABLE_LOW) |=>
      hrdata == {26'h0, $past(objectInUse)})
    else $error("in-use read mismatch");
  a_upper_use_zero:
    assert property ((rdTaken && haddr[7:0] == OFS_OBJECT_ENABLE_HIGH) |=> hrdata == 32'h0)
    else $error("upper in-use byte not zero");
  a_upper_status_zero:
    assert property ((rdTaken && haddr[7:0] == OFS_OBJECT_IRQ_STATUS_HIGH) |=> hrdata == 32'h0)
    else $error("upper status byte not zero");
endmodule

// [test/can_node_model.sv]
// Far-side CAN node: drives one dominant run of whole bits on the bus.
// Assumes the bench gives the run length in bits and the bit length in clocks.
`timescale 1ns/1ps
module can_node_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [31:0] runBits,
  input wire logic [31:0] bitClocks,
  output logic rxLine
);
  int left;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left <= 0;
    end else if (go) begin
      left <= runBits * bitClocks;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end

  // Released bus falls back to the recessive pull level
  assign rxLine = (left > 0) ? 1'b0 : 1'b1;
endmodule
